// file: dcc_analog_model.sv
/*
 * Behavioural model of the two analog comparators and their input
 * multiplexers, turning port B pin levels into result levels.
 * Assumes 8-bit level codes per pin and fixed reference levels.
 */
`timescale 1ns/1ns
module dcc_analog_model #(
    parameter logic [7:0] BANDGAP = 8'h40,
    parameter logic [7:0] MIDRAIL = 8'h80
) (
    // Pin levels
    input  wire logic [7:0] i_pin [8],
    // Controls from the block
    input  wire logic       i_unit_zero_on,
    input  wire logic       i_unit_one_on,
    input  wire logic       i_zero_minus,
    input  wire logic       i_one_minus,
    input  wire logic [2:0] i_pin_index,
    // Results
    output logic            o_zero_result,
    output logic            o_one_result
);
    logic [7:0] minus0;
    logic [7:0] minus1;
    assign minus0 = i_zero_minus ? MIDRAIL : BANDGAP;
    assign minus1 = i_one_minus ? BANDGAP : i_pin[7];
    assign o_zero_result = i_unit_zero_on && (i_pin[i_pin_index] > minus0);
    assign o_one_result  = i_unit_one_on && (i_pin[6] > minus1);
endmodule

// file: dcc_ctrl.sv
/*
 * Dual comparator control: control registers, synchronised comparator
 * results, change flags and the shared comparator interrupt request.
 * Assumes the analog cores produce asynchronous result levels and the
 * register master follows the plain one-cycle strobe protocol.
 */
// Operation
// RQ1: Control one bit 4 picks comparator one minus input, port B pin 7 or bandgap.
// RQ2: Control one bit 1 enables comparator one interrupt.
// RQ3: Bit 0 of each control register switches that comparator on.
// RQ4: Status bits 3 and 2 show synchronised results of comparators one and zero.
// RQ5: A disabled comparator reads its result bit as zero.
// RQ6: A toggle of a comparator result sets its change flag, bit 1 or bit 0.
// RQ7: A set flag requests an interrupt only when its enable bit is one.
// RQ8: Writing one to a flag clears it and drops its request.
// RQ9: Select register bits 2 to 0 give the port B pin for comparator zero plus input.
// RQ10: Both comparators share one interrupt request line.
// RQ11: Control zero bit 4 picks bandgap when 0 and mid-rail when 1.
// RQ12: A result is one when plus input exceeds minus input.
// RQ13: Change is seen between consecutive synced samples while on; writing 0 keeps flags.
// RQ14: An event in the clearing cycle keeps the flag set.
`timescale 1ns/1ns
module dcc_ctrl
    import dcc_pkg::*;
(
    // Clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_srst,
    // Register port
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    // Analog comparator results, asynchronous
    input  wire logic        i_compare_zero_result,
    input  wire logic        i_compare_one_result,
    // Analog controls
    output logic             o_unit_zero_on,
    output logic             o_unit_one_on,
    output logic             o_zero_minus_input_choice,
    output logic             o_one_minus_input_choice,
    output logic      [2:0]  o_plus_input_pin_index,
    // Shared interrupt
    output logic             o_irq
);

    logic [1:0] on_reg;
    logic [1:0] irqen_reg;
    logic [1:0] minus_reg;
    logic [2:0] psel_reg;
    logic [1:0] flag_reg;
    logic [1:0] res_reg;
    logic [1:0] raw;
    logic [1:0] synced;
    logic [1:0] res_next;
    logic [1:0] event_hit;
    logic       wr_ctl0;
    logic       wr_ctl1;
    logic       wr_stat;
    logic       wr_psel;

    assign raw = {i_compare_one_result, i_compare_zero_result};

    always_comb begin
        wr_ctl0 = 1'b0;
        wr_ctl1 = 1'b0;
        wr_stat = 1'b0;
        wr_psel = 1'b0;
        if (i_wr && i_addr == DCC_OFF_CTL0) begin
            wr_ctl0 = 1'b1;
        end else if (i_wr && i_addr == DCC_OFF_CTL1) begin
            wr_ctl1 = 1'b1;
        end else if (i_wr && i_addr == DCC_OFF_STATUS) begin
            wr_stat = 1'b1;
        end else if (i_wr && i_addr == DCC_OFF_PSEL) begin
            wr_psel = 1'b1;
        end
    end

    // RQ1 RQ2 RQ3 RQ11 control bits
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            on_reg    <= DCC_CTL_RESET[1:0];
            irqen_reg <= DCC_CTL_RESET[1:0];
            minus_reg <= DCC_CTL_RESET[1:0];
        end else begin
            if (wr_ctl0) begin
                on_reg[0]    <= i_wdata[DCC_BIT_ON];
                irqen_reg[0] <= i_wdata[DCC_BIT_IRQEN];
                minus_reg[0] <= i_wdata[DCC_BIT_MINUS];
            end
            if (wr_ctl1) begin
                on_reg[1]    <= i_wdata[DCC_BIT_ON];
                irqen_reg[1] <= i_wdata[DCC_BIT_IRQEN];
                minus_reg[1] <= i_wdata[DCC_BIT_MINUS];
            end
        end
    end

    // RQ9 plus input pin index
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            psel_reg <= DCC_PSEL_RESET;
        end else if (wr_psel) begin
            psel_reg <= i_wdata[DCC_PSEL_W-1:0];
        end
    end

    // Three-stage synchroniser per comparator; stage 0 feeds only stage 1
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_sync
            logic [DCC_SYNC_STAGES-1:0] sync_reg;
            always_ff @(posedge i_mclk) begin
                if (i_srst) begin
                    sync_reg <= '0;
                end else begin
                    sync_reg <= {sync_reg[DCC_SYNC_STAGES-2:0], raw[g]};
                end
            end
            // RQ4 RQ12 agreed sample
            assign synced[g] = (sync_reg[1] == sync_reg[2])
                             ? sync_reg[2] : res_reg[g];
            // RQ5 zero while off
            assign res_next[g] = on_reg[g] & synced[g];
            // RQ13 change while on
            assign event_hit[g] = on_reg[g] & (res_next[g] != res_reg[g]);
        end
    endgenerate

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            res_reg <= 2'h0;
        end else begin
            res_reg <= res_next;
        end
    end

    // RQ6 RQ8 RQ14 flags, set beats clear
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            flag_reg <= 2'h0;
        end else begin
            flag_reg <= event_hit |
                (flag_reg & ~({2{wr_stat}} &
                 i_wdata[DCC_BIT_FLAG1:DCC_BIT_FLAG0]));
        end
    end

    // RQ7 RQ10 shared request
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(flag_reg & irqen_reg);
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_rd && i_addr == DCC_OFF_CTL0) begin
            o_rdata <= {27'h0, minus_reg[0], 2'h0, irqen_reg[0], on_reg[0]};
        end else if (i_rd && i_addr == DCC_OFF_CTL1) begin
            o_rdata <= {27'h0, minus_reg[1], 2'h0, irqen_reg[1], on_reg[1]};
        end else if (i_rd && i_addr == DCC_OFF_STATUS) begin
            o_rdata <= {28'h0, res_reg, flag_reg};
        end else if (i_rd && i_addr == DCC_OFF_PSEL) begin
            o_rdata <= {29'h0, psel_reg};
        end else begin
            o_rdata <= 32'h0000_0000;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_unit_zero_on            <= 1'b0;
            o_unit_one_on             <= 1'b0;
            o_zero_minus_input_choice <= 1'b0;
            o_one_minus_input_choice  <= 1'b0;
            o_plus_input_pin_index    <= 3'h0;
        end else begin
            o_unit_zero_on            <= on_reg[0];
            o_unit_one_on             <= on_reg[1];
            o_zero_minus_input_choice <= minus_reg[0];
            o_one_minus_input_choice  <= minus_reg[1];
            o_plus_input_pin_index    <= psel_reg;
        end
    end

    // Write paths: register edge, then output edge
    sequence s_ctl0_write;
        wr_ctl0 ##1 1'b1;
    endsequence

    sequence s_ctl1_write;
        wr_ctl1 ##1 1'b1;
    endsequence

    sequence s_psel_write;
        wr_psel ##1 1'b1;
    endsequence

    sequence s_status_read;
        i_rd && i_addr == DCC_OFF_STATUS;
    endsequence

    // RQ5 off reads zero
    a_off_zero_res0: assert property ( // RQ5
        @(posedge i_mclk) disable iff (i_srst)
        !on_reg[0] |=> !res_reg[0])
        else $error("result zero set while off");

    // RQ5 off reads zero
    a_off_zero_res1: assert property ( // RQ5
        @(posedge i_mclk) disable iff (i_srst)
        !on_reg[1] |=> !res_reg[1])
        else $error("result one set while off");

    // RQ6 toggle sets flag
    a_toggle_flag_zero: assert property ( // RQ6
        @(posedge i_mclk) disable iff (i_srst)
        event_hit[0] |=> flag_reg[0])
        else $error("flag zero not set");

    // RQ6 toggle sets flag
    a_toggle_flag_one: assert property ( // RQ6
        @(posedge i_mclk) disable iff (i_srst)
        event_hit[1] |=> flag_reg[1])
        else $error("flag one not set");

    // RQ6 no spurious set
    a_flag_quiet_zero: assert property ( // RQ6
        @(posedge i_mclk) disable iff (i_srst)
        !flag_reg[0] && !event_hit[0] |=> !flag_reg[0])
        else $error("flag zero set without change");

    // RQ6 no spurious set
    a_flag_quiet_one: assert property ( // RQ6
        @(posedge i_mclk) disable iff (i_srst)
        !flag_reg[1] && !event_hit[1] |=> !flag_reg[1])
        else $error("flag one set without change");

    // RQ8 clear by one
    a_w1c_zero: assert property ( // RQ8
        @(posedge i_mclk) disable iff (i_srst)
        wr_stat && i_wdata[0] && !event_hit[0] |=> !flag_reg[0])
        else $error("flag zero not cleared");

    // RQ8 clear by one
    a_w1c_one: assert property ( // RQ8
        @(posedge i_mclk) disable iff (i_srst)
        wr_stat && i_wdata[1] && !event_hit[1] |=> !flag_reg[1])
        else $error("flag one not cleared");

    // RQ13 write zero keeps
    a_w0_keeps_zero: assert property ( // RQ13
        @(posedge i_mclk) disable iff (i_srst)
        flag_reg[0] && !(wr_stat && i_wdata[0]) |=> flag_reg[0])
        else $error("flag zero lost");

    // RQ13 write zero keeps
    a_w0_keeps_one: assert property ( // RQ13
        @(posedge i_mclk) disable iff (i_srst)
        flag_reg[1] && !(wr_stat && i_wdata[1]) |=> flag_reg[1])
        else $error("flag one lost");

    // RQ14 set wins
    a_set_wins_zero: assert property ( // RQ14
        @(posedge i_mclk) disable iff (i_srst)
        event_hit[0] && wr_stat && i_wdata[0] |=> flag_reg[0])
        else $error("event zero lost on clear");

    // RQ14 set wins
    a_set_wins_one: assert property ( // RQ14
        @(posedge i_mclk) disable iff (i_srst)
        event_hit[1] && wr_stat && i_wdata[1] |=> flag_reg[1])
        else $error("event one lost on clear");

    // RQ7 enabled flag requests
    a_irq_flag_zero: assert property ( // RQ7
        @(posedge i_mclk) disable iff (i_srst)
        flag_reg[0] && irqen_reg[0] |=> o_irq)
        else $error("no request for flag zero");

    // RQ10 unit one requests
    a_irq_flag_one: assert property ( // RQ10
        @(posedge i_mclk) disable iff (i_srst)
        flag_reg[1] && irqen_reg[1] |=> o_irq)
        else $error("no request for flag one");

    // RQ7 masked flags quiet
    a_irq_masked: assert property ( // RQ7
        @(posedge i_mclk) disable iff (i_srst)
        !(flag_reg[0] && irqen_reg[0]) && !(flag_reg[1] && irqen_reg[1])
        |=> !o_irq)
        else $error("request without enabled flag");

    // RQ2 enable bit stored
    a_irqen_write: assert property ( // RQ2
        @(posedge i_mclk) disable iff (i_srst)
        wr_ctl1 |=> irqen_reg[1] == $past(i_wdata[DCC_BIT_IRQEN]))
        else $error("interrupt enable one wrong");

    // RQ3 on bit held
    a_on_hold: assert property ( // RQ3
        @(posedge i_mclk) disable iff (i_srst)
        !wr_ctl0 |=> on_reg[0] == $past(on_reg[0]))
        else $error("unit zero on changed");

    // RQ3 unit zero output
    a_on_zero_drive: assert property ( // RQ3
        @(posedge i_mclk) disable iff (i_srst)
        s_ctl0_write |=> o_unit_zero_on == $past(i_wdata[0], 2))
        else $error("unit zero on wrong");

    // RQ3 unit one output
    a_on_one_drive: assert property ( // RQ3
        @(posedge i_mclk) disable iff (i_srst)
        s_ctl1_write |=> o_unit_one_on == $past(i_wdata[0], 2))
        else $error("unit one on wrong");

    // RQ11 zero minus output
    a_minus_zero_drive: assert property ( // RQ11
        @(posedge i_mclk) disable iff (i_srst)
        s_ctl0_write |=> o_zero_minus_input_choice == $past(i_wdata[4], 2))
        else $error("zero minus choice wrong");

    // RQ1 one minus output
    a_minus_one_drive: assert property ( // RQ1
        @(posedge i_mclk) disable iff (i_srst)
        s_ctl1_write |=> o_one_minus_input_choice == $past(i_wdata[4], 2))
        else $error("one minus choice wrong");

    // RQ9 pin index
    a_psel_write: assert property ( // RQ9
        @(posedge i_mclk) disable iff (i_srst)
        s_psel_write |=> o_plus_input_pin_index == $past(i_wdata[2:0], 2))
        else $error("pin index wrong");

    // RQ4 result bits read
    a_status_res_read: assert property ( // RQ4
        @(posedge i_mclk) disable iff (i_srst)
        s_status_read |=> o_rdata[3:2] == $past(res_reg))
        else $error("status result bits wrong");

    // RQ6 flag bits read
    a_status_flag_read: assert property ( // RQ6
        @(posedge i_mclk) disable iff (i_srst)
        s_status_read |=> o_rdata[1:0] == $past(flag_reg))
        else $error("status flag bits wrong");

    // RQ4 agreed sample taken
    a_res_agree_zero: assert property ( // RQ4
        @(posedge i_mclk) disable iff (i_srst)
        on_reg[0] && g_sync[0].sync_reg[1] == g_sync[0].sync_reg[2]
        |=> res_reg[0] == $past(g_sync[0].sync_reg[2]))
        else $error("result zero not synchronised");

    // RQ12 agreed sample taken
    a_res_agree_one: assert property ( // RQ12
        @(posedge i_mclk) disable iff (i_srst)
        on_reg[1] && g_sync[1].sync_reg[1] == g_sync[1].sync_reg[2]
        |=> res_reg[1] == $past(g_sync[1].sync_reg[2]))
        else $error("result one not synchronised");

endmodule

// file: dcc_pkg.sv
/*
 * Package for the dual comparator control block: register offsets,
 * field positions, reset values and synchroniser depth.
 * Assumes a 32-bit plain register port with byte addresses.
 */
package dcc_pkg;
    localparam logic [7:0] DCC_OFF_CTL0   = 8'h00;
    localparam logic [7:0] DCC_OFF_CTL1   = 8'h04;
    localparam logic [7:0] DCC_OFF_STATUS = 8'h08;
    localparam logic [7:0] DCC_OFF_PSEL   = 8'h0C;

    localparam int DCC_BIT_ON     = 0;
    localparam int DCC_BIT_IRQEN  = 1;
    localparam int DCC_BIT_MINUS  = 4;
    localparam int DCC_BIT_FLAG0  = 0;
    localparam int DCC_BIT_FLAG1  = 1;
    localparam int DCC_BIT_RES0   = 2;
    localparam int DCC_BIT_RES1   = 3;
    localparam int DCC_PSEL_W     = 3;

    localparam logic [31:0] DCC_CTL_RESET  = 32'h0000_0000;
    localparam logic [2:0]  DCC_PSEL_RESET = 3'h0;
    localparam int          DCC_SYNC_STAGES = 3;
endpackage

// file: test_dcc_ctrl.sv
/*
 * Testbench for the dual comparator control block with analog model.
 * Assumes the plain one-cycle register strobes and a 50 MHz clock.
 */
`timescale 1ns/1ns
module test_dcc_ctrl
    import dcc_pkg::*;
;
    logic        i_mclk, i_srst, i_wr, i_rd, r0, r1, on0, on1, m0, m1, irq;
    logic [7:0]  i_addr;
    logic [31:0] i_wdata, o_rdata, d;
    logic [2:0]  idx;
    logic [7:0]  pin [8];
    int          n_fail, n_checks;

    dcc_ctrl i_dcc_ctrl (.i_mclk(i_mclk), .i_srst(i_srst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_compare_zero_result(r0), .i_compare_one_result(r1),
        .o_unit_zero_on(on0), .o_unit_one_on(on1),
        .o_zero_minus_input_choice(m0), .o_one_minus_input_choice(m1),
        .o_plus_input_pin_index(idx), .o_irq(irq));
    dcc_analog_model i_dcc_analog_model (.i_pin(pin), .i_unit_zero_on(on0),
        .i_unit_one_on(on1), .i_zero_minus(m0), .i_one_minus(m1),
        .i_pin_index(idx), .o_zero_result(r0), .o_one_result(r1));

    initial i_mclk = 1'b0;
    always #10 i_mclk = ~i_mclk;

    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_mclk);
        i_addr <= a; i_wdata <= v; i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge i_mclk);
        i_addr <= a; i_rd <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    task automatic settle;
        repeat (12) @(posedge i_mclk);
        #1;
    endtask
    task automatic report_and_stop;
        if (n_fail == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic t_reset;
        rd(DCC_OFF_CTL1); chk("ctl1", d, DCC_CTL_RESET);
        rd(DCC_OFF_PSEL); chk("psel", d, 32'h0000_0000);
        rd(DCC_OFF_STATUS); chk("status", d, 32'h0000_0000);
        chk("irq", {31'h0, irq}, 32'h0);
    endtask
    task automatic t_controls;
        wr(DCC_OFF_CTL1, 32'h0000_0013);
        wr(DCC_OFF_PSEL, 32'hFFFF_FFFD);
        settle;
        rd(DCC_OFF_CTL1); chk("ctl1", d, 32'h0000_0013);
        chk("one minus", {31'h0, m1}, 32'h1);
        chk("one on", {31'h0, on1}, 32'h1);
        chk("pin index", {29'h0, idx}, 32'h5);
        rd(8'h10); chk("unmapped", d, 32'h0000_0000);
        wr(DCC_OFF_CTL1, 32'h0000_0000);
    endtask
    task automatic t_events;
        wr(DCC_OFF_CTL0, 32'h0000_0003);
        pin[5] <= 8'h50;
        settle;
        rd(DCC_OFF_STATUS); chk("rise0", d, 32'h0000_0005);
        chk("irq0", {31'h0, irq}, 32'h1);
        wr(DCC_OFF_STATUS, 32'h0000_0000); settle;
        rd(DCC_OFF_STATUS); chk("keep0", d, 32'h0000_0005);
        wr(DCC_OFF_STATUS, 32'h0000_0001); settle;
        rd(DCC_OFF_STATUS); chk("clr0", d, 32'h0000_0004);
        chk("irq clr", {31'h0, irq}, 32'h0);
        wr(DCC_OFF_CTL0, 32'h0000_0013); settle;
        chk("zero minus", {31'h0, m0}, 32'h1);
        chk("zero on", {31'h0, on0}, 32'h1);
        rd(DCC_OFF_STATUS); chk("fall0", d, 32'h0000_0001);
        wr(DCC_OFF_STATUS, 32'h0000_0001);
        wr(DCC_OFF_CTL1, 32'h0000_0011);
        pin[6] <= 8'h60;
        settle;
        rd(DCC_OFF_STATUS); chk("rise1", d, 32'h0000_000A);
        chk("irq masked", {31'h0, irq}, 32'h0);
        wr(DCC_OFF_CTL1, 32'h0000_0013); settle;
        chk("irq1", {31'h0, irq}, 32'h1);
        wr(DCC_OFF_STATUS, 32'h0000_0002); settle;
        chk("irq1 clr", {31'h0, irq}, 32'h0);
        wr(DCC_OFF_CTL0, 32'h0000_0001); settle;
        wr(DCC_OFF_CTL0, 32'h0000_0000); settle;
        rd(DCC_OFF_STATUS); chk("off0", d & 32'h4, 32'h0);
    endtask

    initial begin
        n_fail = 0;
        n_checks = 0;
        i_srst = 1'b1;
        i_addr = 8'h00;
        i_wdata = 32'h0000_0000;
        i_wr = 1'b0;
        i_rd = 1'b0;
        foreach (pin[k]) pin[k] = 8'h00;
        repeat (12) @(posedge i_mclk);
        i_srst <= 1'b0;
        t_reset;
        t_controls;
        t_events;
        report_and_stop;
    end
endmodule
